// file: rtl/capture_ctrl_pkg.sv
// shared constants, carrier type and edge decode for the capture edge controller
package capture_ctrl_pkg;

   // channel count and captured counter width
   localparam int CHANNELS = 8;
   localparam int COUNT_W = 16;
   localparam int NARROW_PA = 4;

   // register byte offsets on the apb bus
   localparam logic [11:0] OFS_EDGE_HIGH = 12'h000;
   localparam logic [11:0] OFS_EDGE_LOW = 12'h004;
   localparam logic [11:0] OFS_GUARD = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00c;
   localparam logic [11:0] OFS_CAPTURE = 12'h040;
   localparam logic [11:0] OFS_HOLD = 12'h060;

   // values after reset
   localparam logic [7:0] RST_EDGE = 8'h00;
   localparam logic [7:0] RST_GUARD = 8'h00;

   // edge field codes, high bit then low bit
   localparam logic [1:0] EDGE_OFF = 2'b00;
   localparam logic [1:0] EDGE_RISE = 2'b01;
   localparam logic [1:0] EDGE_FALL = 2'b10;
   localparam logic [1:0] EDGE_ANY = 2'b11;

   // one capture or holding slot: occupancy flag plus value
   typedef struct packed {
      logic full;
      logic [COUNT_W-1:0] value;
   } slot_s;

   // low bit arms rising edges, high bit arms falling edges
   function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
      edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
   endfunction

endpackage

// file: rtl/capture_edge_and_overwrite_ctrl.sv
// apb register file, edge selection and overwrite guard for eight capture channels
`timescale 1ns/1ps
module capture_edge_and_overwrite_ctrl
   import capture_ctrl_pkg::*;
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [CHANNELS-1:0] CAPTURE_PIN,
   input wire logic [COUNT_W-1:0] TIMER_COUNT,
   input wire logic LATCH_STROBE,
   output logic [NARROW_PA-1:0] NARROW_PA_EDGE,
   output logic WIDE_PA_EDGE
);

   logic [7:0] edge_control_high_channels;
   logic [7:0] edge_control_low_channels;
   logic [7:0] capture_overwrite_guard;
   logic ack;
   logic [CHANNELS-1:0] edge_seen;
   logic [CHANNELS-1:0] rd_cap;
   logic [CHANNELS-1:0] rd_hold;
   logic [CHANNELS-1:0] cap_full;
   logic [CHANNELS-1:0] hold_full;
   slot_s cap [CHANNELS];
   slot_s hold [CHANNELS];

   // apb phases: one wait state so read data and read side effects share an edge
   wire access = PSEL && PENABLE;
   wire first = access && !ack;
   wire done = access && ack;
   assign PREADY = ack;

   // address decode
   wire sel_high = PADDR == OFS_EDGE_HIGH;
   wire sel_low = PADDR == OFS_EDGE_LOW;
   wire sel_guard = PADDR == OFS_GUARD;
   wire sel_status = PADDR == OFS_STATUS;
   wire sel_cap = (PADDR[11:5] == OFS_CAPTURE[11:5]) && (PADDR[1:0] == 2'b00);
   wire sel_hold = (PADDR[11:5] == OFS_HOLD[11:5]) && (PADDR[1:0] == 2'b00);
   wire [2:0] slot_idx = PADDR[4:2];
   wire mapped = sel_high || sel_low || sel_guard || sel_status || sel_cap || sel_hold;
   assign PSLVERR = ack && !mapped;

   // writes land at the completing edge, byte lane 0 only
   wire wr_lane = done && PWRITE && PSTRB[0];
   wire wr_high = wr_lane && sel_high;
   wire wr_low = wr_lane && sel_low;
   wire wr_guard = wr_lane && sel_guard;
   wire rd_first = first && !PWRITE;

   // read mux; capture and holding words carry the full flag in bit 16
   wire slot_s cap_pick = cap[slot_idx];
   wire slot_s hold_pick = hold[slot_idx];
   wire [31:0] next_rdata =
      sel_high ? {24'h000000, edge_control_high_channels} :
      sel_low ? {24'h000000, edge_control_low_channels} :
      sel_guard ? {24'h000000, capture_overwrite_guard} :
      sel_status ? {16'h0000, hold_full, cap_full} :
      sel_cap ? {15'h0000, cap_pick} :
      sel_hold ? {15'h0000, hold_pick} : 32'h00000000;

   // bus handshake and read data flops
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         ack <= 1'b0;
         PRDATA <= 32'h00000000;
      end else begin
         ack <= first;
         if (rd_first) begin
            PRDATA <= next_rdata;
         end
      end
   end

   // control registers, all zero after reset
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         edge_control_high_channels <= RST_EDGE;
         edge_control_low_channels <= RST_EDGE;
         capture_overwrite_guard <= RST_GUARD;
      end else begin
         if (wr_high) begin
            edge_control_high_channels <= PWDATA[7:0];
         end
         if (wr_low) begin
            edge_control_low_channels <= PWDATA[7:0];
         end
         if (wr_guard) begin
            capture_overwrite_guard <= PWDATA[7:0];
         end
      end
   end

   // channel n takes bits 2n+1:2n of the joined edge fields
   wire [15:0] edge_fields = {edge_control_high_channels, edge_control_low_channels};

   // channels; the read that empties a slot is taken with its data
   genvar i;
   generate
      for (i = 0; i < CHANNELS; i++) begin : g_chan
         assign rd_cap[i] = rd_first && sel_cap && (slot_idx == 3'(i));
         assign rd_hold[i] = rd_first && sel_hold && (slot_idx == 3'(i));
         assign cap_full[i] = cap[i].full;
         assign hold_full[i] = hold[i].full;
         edge_capture_channel u_chan (
            .clk(CLOCK),
            .rst(SYS_RST),
            .pin(CAPTURE_PIN[i]),
            .sel(edge_fields[2*i +: 2]),
            .guard(capture_overwrite_guard[i]),
            .counter(TIMER_COUNT),
            .latch(LATCH_STROBE),
            .rd_cap(rd_cap[i]),
            .rd_hold(rd_hold[i]),
            .edge_seen(edge_seen[i]),
            .cap(cap[i]),
            .hold(hold[i])
         );
      end
   endgenerate

   // accumulator edges reuse the channel detectors, so they fire even when
   // a guarded channel refuses the capture itself
   assign NARROW_PA_EDGE = edge_seen[NARROW_PA-1:0];
   assign WIDE_PA_EDGE = edge_seen[0];

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);

   // checked only on the first edge after release, so the power-up edge is left alone
   a_reset_clears: assert property (@(posedge CLOCK) disable iff (1'b0)
      $past(SYS_RST) && !SYS_RST |-> edge_fields == {RST_EDGE, RST_EDGE}
      && capture_overwrite_guard == RST_GUARD)
      else $error("edge or guard register not cleared by reset");
   a_low_write: assert property (access && ack && PWRITE && PSTRB[0]
      && PADDR == OFS_EDGE_LOW |=> edge_control_low_channels == $past(PWDATA[7:0]))
      else $error("write to low edge register lost");
   a_high_readback: assert property (rd_first && sel_high
      |=> PREADY && PRDATA == {24'h000000, edge_control_high_channels})
      else $error("high edge register read back wrong");
   a_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("apb access not answered after one wait state");
   a_narrow_zero: assert property (edge_control_low_channels[1:0] == EDGE_OFF
      |-> !NARROW_PA_EDGE[0] && !WIDE_PA_EDGE)
      else $error("accumulator edge while channel 0 field disabled");
   // a wide pulse that the guard lets through must land in channel 0
   a_wide_rise: assert property (edge_control_low_channels[1:0] == EDGE_RISE
      && WIDE_PA_EDGE && !(capture_overwrite_guard[0] && cap[0].full)
      |=> cap[0].full && cap[0].value == $past(TIMER_COUNT))
      else $error("wide accumulator edge without channel 0 capture");
   a_status_guard: assert property (capture_overwrite_guard[1] && cap_full[1]
      && !rd_cap[1] && !LATCH_STROBE |=> cap_full[1])
      else $error("guarded full slot emptied without read or latch");

   c_blocked: cover property (capture_overwrite_guard[1] && cap[1].full && edge_seen[1]);
   c_latch: cover property (LATCH_STROBE && cap[1].full && !hold[1].full);
   c_read_clear: cover property (rd_cap[2] ##2 !cap[2].full);
   c_any_edge: cover property (edge_fields[15:14] == EDGE_ANY && edge_seen[7]);

endmodule // capture_edge_and_overwrite_ctrl

// file: rtl/edge_capture_channel.sv
// one input capture channel: pin synchroniser, edge detect, capture and holding slots
`timescale 1ns/1ps
module edge_capture_channel
   import capture_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   input wire logic [1:0] sel,
   input wire logic guard,
   input wire logic [COUNT_W-1:0] counter,
   input wire logic latch,
   input wire logic rd_cap,
   input wire logic rd_hold,
   output logic edge_seen,
   output slot_s cap,
   output slot_s hold
);

   logic s1;
   logic s2;
   logic s3;
   slot_s next_cap;
   slot_s next_hold;

   // two flops against metastability, a third for the previous level
   always_ff @(posedge clk) begin
      if (rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // edge decode and slot update conditions
   assign edge_seen = edge_hit(sel, s3, s2);
   wire cap_write = edge_seen && (!guard || !cap.full);
   wire xfer = latch && cap.full && (!guard || !hold.full);

   // a capture in the same cycle as a read keeps the slot full
   assign next_cap.full = cap_write ? 1'b1 : ((rd_cap || xfer) ? 1'b0 : cap.full);
   assign next_cap.value = cap_write ? counter : cap.value;
   assign next_hold.full = xfer ? 1'b1 : (rd_hold ? 1'b0 : hold.full);
   assign next_hold.value = xfer ? cap.value : hold.value;

   // slot registers
   always_ff @(posedge clk) begin
      if (rst) begin
         cap <= '0;
         hold <= '0;
      end else begin
         cap <= next_cap;
         hold <= next_hold;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_disabled_quiet: assert property (sel == EDGE_OFF |-> !edge_seen)
      else $error("edge reported while capture disabled");
   a_rise_capture: assert property ((sel == EDGE_RISE) && !s3 && s2
      && !(guard && cap.full) |=> cap.full && cap.value == $past(counter))
      else $error("rising edge not captured");
   a_fall_ignored: assert property ((sel == EDGE_RISE) && s3 && !s2 |-> !edge_seen)
      else $error("falling edge seen in rising-only mode");
   a_free_overwrite: assert property (!guard && edge_seen
      |=> cap.full && cap.value == $past(counter))
      else $error("unguarded capture did not overwrite");
   a_guard_keeps: assert property (guard && cap.full && !rd_cap && !latch
      |=> cap.full && $stable(cap.value))
      else $error("guarded capture value changed");
   a_read_empties: assert property (rd_cap && !edge_seen |=> !cap.full)
      else $error("read did not empty capture slot");
   a_latch_moves: assert property (latch && cap.full && !hold.full && !edge_seen
      |=> hold.full && !cap.full && hold.value == $past(cap.value))
      else $error("latch did not move capture to holding");

endmodule // edge_capture_channel

// file: verification/tb.sv
// self-checking bench for the capture edge and overwrite controller
`timescale 1ns/1ps
module tb
   import capture_ctrl_pkg::*;
;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [CHANNELS-1:0] pin = 8'h00;
   logic [COUNT_W-1:0] count = 16'h0000;
   logic latch = 1'b0;
   logic [NARROW_PA-1:0] narrow_edge;
   logic wide_edge;
   logic [31:0] rdat;
   logic err;
   int bad_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int narrow [4];
   int wide = 0;

   capture_edge_and_overwrite_ctrl dut (.CLOCK(clock), .SYS_RST(sys_rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CAPTURE_PIN(pin),
      .TIMER_COUNT(count), .LATCH_STROBE(latch), .NARROW_PA_EDGE(narrow_edge),
      .WIDE_PA_EDGE(wide_edge));

   always #5 clock = ~clock;

   // pulse counters, and a ceiling so a hung handshake still ends the run
   always @(posedge clock) begin
      for (int k = 0; k < 4; k++) if (narrow_edge[k] === 1'b1) narrow[k]++;
      if (wide_edge === 1'b1) wide++;
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; pready, read data and error are taken at the rising edge
   // that samples pready high, and only then is the request released
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // one rise and one fall on a pin, spaced beyond the synchroniser delay
   task automatic pulse(input int ch, input logic [15:0] v);
      count <= v;
      @(posedge clock) pin[ch] <= 1'b1;
      repeat (6) @(posedge clock);
      pin[ch] <= 1'b0;
      repeat (6) @(posedge clock);
   endtask

   task automatic strobe();
      @(posedge clock) latch <= 1'b1;
      @(posedge clock) latch <= 1'b0;
      repeat (2) @(posedge clock);
   endtask

   task automatic t_regs();
      apb(1'b0, OFS_EDGE_HIGH, 32'h0);
      chk(rdat, 32'(RST_EDGE));
      apb(1'b0, OFS_EDGE_LOW, 32'h0);
      chk(rdat, 32'(RST_EDGE));
      apb(1'b0, OFS_GUARD, 32'h0);
      chk(rdat, 32'(RST_GUARD));
      apb(1'b1, OFS_EDGE_HIGH, 32'ha5);
      apb(1'b1, OFS_EDGE_LOW, 32'h5a);
      apb(1'b0, OFS_EDGE_HIGH, 32'h0);
      chk(rdat, 32'ha5);
      apb(1'b0, OFS_EDGE_LOW, 32'h0);
      chk(rdat, 32'h5a);
      apb(1'b0, 12'h100, 32'h0);
      chk({err, rdat[30:0]}, 32'h80000000);
      apb(1'b1, OFS_EDGE_HIGH, 32'h0);
      $display("test regs done");
   endtask

   // every mode on every narrow lane; channel 0 also drives the wide lane
   task automatic t_modes();
      for (int ch = 0; ch < 4; ch++) begin
         for (int m = 0; m < 4; m++) begin
            apb(1'b1, OFS_EDGE_LOW, 32'(m) << (2 * ch));
            narrow = '{default: 0};
            wide = 0;
            pulse(ch, 16'h1234);
            for (int k = 0; k < 4; k++) chk(32'(narrow[k]), (k == ch) ? 32'(m % 2 + m / 2) : 0);
            chk(32'(wide), (ch == 0) ? 32'(m % 2 + m / 2) : 0);
            apb(1'b0, OFS_CAPTURE + 12'(4 * ch), 32'h0);
            chk({15'h0, rdat[16:0]}, (m != 0) ? 32'h00011234 : 32'h00000000);
         end
      end
      $display("test modes done");
   endtask

   // channel 1 on rising edges, overwrite guard off and on, capture and latch
   task automatic t_guard();
      apb(1'b1, OFS_EDGE_LOW, 32'h04);
      pulse(1, 16'h1111);
      pulse(1, 16'h2222);
      apb(1'b0, OFS_CAPTURE + 12'h004, 32'h0);
      chk(rdat, 32'h00012222);
      apb(1'b0, OFS_CAPTURE + 12'h004, 32'h0);
      chk(32'(rdat[16]), 32'h0);
      apb(1'b1, OFS_GUARD, 32'h02);
      pulse(1, 16'h1111);
      pulse(1, 16'h2222);
      apb(1'b0, OFS_CAPTURE + 12'h004, 32'h0);
      chk(rdat, 32'h00011111);
      pulse(1, 16'h3333);
      strobe();
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rdat, 32'h00000200);
      pulse(1, 16'h4444);
      strobe();
      apb(1'b0, OFS_HOLD + 12'h004, 32'h0);
      chk(rdat, 32'h00013333);
      apb(1'b0, OFS_CAPTURE + 12'h004, 32'h0);
      chk(rdat, 32'h00014444);
      apb(1'b1, OFS_GUARD, 32'h00);
      pulse(1, 16'h5555);
      strobe();
      pulse(1, 16'h6666);
      strobe();
      apb(1'b0, OFS_HOLD + 12'h004, 32'h0);
      chk(rdat, 32'h00016666);
      $display("test guard done");
   endtask

   // high register: channel 7 on either edge, channel 6 on falling edges behind
   // its guard, so a wrong rising capture would block the falling one; the count
   // moves between the edges to tell them apart; then a reset in mid-run
   task automatic t_high();
      apb(1'b1, OFS_EDGE_HIGH, 32'he0);
      apb(1'b1, OFS_GUARD, 32'h40);
      count <= 16'h7701;
      pin[7:6] <= 2'b11;
      repeat (6) @(posedge clock);
      count <= 16'h7702;
      pin[7:6] <= 2'b00;
      repeat (6) @(posedge clock);
      apb(1'b0, OFS_CAPTURE + 12'h01c, 32'h0);
      chk(rdat, 32'h00017702);
      apb(1'b0, OFS_CAPTURE + 12'h018, 32'h0);
      chk(rdat, 32'h00017702);
      pulse(7, 16'h0777);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      apb(1'b0, OFS_EDGE_HIGH, 32'h0);
      chk(rdat, 32'(RST_EDGE));
      apb(1'b0, OFS_GUARD, 32'h0);
      chk(rdat, 32'(RST_GUARD));
      apb(1'b0, OFS_CAPTURE + 12'h01c, 32'h0);
      chk(rdat, 32'h00000000);
      $display("test high done");
   endtask

   initial begin
      narrow = '{default: 0};
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      t_regs();
      t_modes();
      t_guard();
      t_high();
      wrap_up();
   end
endmodule // tb
